/* File: hdl/sac_pkg.sv */
/*
 * Constants for the successive-approximation converter control block:
 * register addresses, field positions, reset values, start sources and
 * conversion clock counts.
 * Assumes an 8-bit special function register port with 8-bit addresses.
 */
package sac_pkg;

    // Register addresses
    localparam logic [7:0] SAC_ADDR_CONFIG = 8'hBC;
    localparam logic [7:0] SAC_ADDR_RES_LOW = 8'hBD;
    localparam logic [7:0] SAC_ADDR_RES_HIGH = 8'hBE;
    localparam logic [7:0] SAC_ADDR_CONTROL = 8'hE8;

    // Configuration fields
    localparam int SAC_CFG_DIV_MSB = 7;
    localparam int SAC_CFG_DIV_LSB = 3;
    localparam int SAC_CFG_JUSTIFY = 2;
    localparam int SAC_CFG_EIGHT = 1;
    localparam int SAC_CFG_GAIN = 0;
    localparam logic [7:0] SAC_CFG_RESET = 8'hF8;

    // Control fields
    localparam int SAC_CTL_ENABLE = 7;
    localparam int SAC_CTL_TRACK = 6;
    localparam int SAC_CTL_DONE = 5;
    localparam int SAC_CTL_BUSY = 4;
    localparam int SAC_CTL_SRC_MSB = 2;
    localparam int SAC_CTL_SRC_LSB = 0;
    localparam logic [7:0] SAC_CTL_RESET = 8'h00;
    localparam logic [7:0] SAC_DATA_RESET = 8'h00;

    // Start sources
    localparam logic [2:0] SAC_SRC_SOFT = 3'h0;
    localparam logic [2:0] SAC_SRC_T0 = 3'h1;
    localparam logic [2:0] SAC_SRC_T2 = 3'h2;
    localparam logic [2:0] SAC_SRC_T1 = 3'h3;

    // Conversion clock counts
    localparam int SAC_CODE_W = 10;
    localparam int SAC_DIV_W = 5;
    localparam int SAC_TICK_W = 5;
    localparam logic [4:0] SAC_DELAY_TICKS = 5'h03;
    localparam logic [4:0] SAC_END_TICKS_10 = 5'h0E;
    localparam logic [4:0] SAC_END_TICKS_8 = 5'h0C;
    localparam logic [9:0] SAC_TRIAL_FIRST = 10'h200;
    localparam logic [9:0] SAC_TRIAL_LAST_8 = 10'h004;

    typedef enum logic [1:0] {
        SAC_IDLE = 2'b00,
        SAC_DELAY = 2'b01,
        SAC_CONV = 2'b10
    } sac_state_e;

endpackage : sac_pkg

/* File: hdl/sac_pin_sync.sv */
/*
 * Three-stage synchroniser for a pin; the level changes only once the
 * second and third stages agree.
 * Assumes the pin is asynchronous to mclk.
 */
`timescale 1ns/1ps
module sac_pin_sync
    import sac_pkg::*;
(
    input wire logic mclk,
    input wire logic nrst,
    input wire logic pin,
    output logic level_q
);

    logic s1_q;
    logic s2_q;
    logic s3_q;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
        end else begin
            s1_q <= pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // Accept a change once stages two and three agree
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            level_q <= 1'b0;
        end else if (s2_q == s3_q) begin
            level_q <= s3_q;
        end
    end

endmodule : sac_pin_sync

/* File: hdl/sac_clk_div.sv */
/*
 * Conversion clock divider: one tick pulse every div + 1 system clocks.
 * Assumes restart is a one-cycle pulse that realigns the tick phase.
 */
`timescale 1ns/1ps
module sac_clk_div
    import sac_pkg::*;
#(
    parameter int DIV_W = SAC_DIV_W
)(
    input wire logic mclk,
    input wire logic nrst,
    input wire logic run,
    input wire logic restart,
    input wire logic [DIV_W-1:0] div,
    output logic tick_q
);

    logic [DIV_W-1:0] cnt_q;

    if (DIV_W < 1 || DIV_W > 8) begin : g_chk
        $error("sac_clk_div: DIV_W out of range");
    end

    // Divide by field value plus one
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            cnt_q <= '0;
            tick_q <= 1'b0;
        end else if (!run || restart) begin
            cnt_q <= '0;
            tick_q <= 1'b0;
        end else if (cnt_q >= div) begin
            cnt_q <= '0;
            tick_q <= 1'b1; // R7
        end else begin
            cnt_q <= cnt_q + 1'b1;
            tick_q <= 1'b0;
        end
    end

endmodule : sac_clk_div

/* File: hdl/sac_ctrl.sv */
/*
 * Control of a 10-bit successive-approximation converter: register port,
 * start source selection, tracking, bit sequencing and result formatting.
 * Assumes the comparator output cmp_in is already timed to mclk and
 * settles within one conversion clock of each new dac_code.
 */
//
// Behaviour
// [R1] Result is a 10-bit unsigned code; full scale 0x03FF right, 0xFFC0 left.
// [R2] Configuration bit 2 selects right (0) or left (1) justification.
// [R3] Result bits not carrying code bits read as zero.
// [R4] Configuration bit 1 selects 8-bit mode: eight MSBs in high byte, justify ignored.
// [R5] 8-bit conversions take two fewer conversion clocks than 10-bit.
// [R6] 8-bit conversion ends at clock 12, or 15 with delayed tracking.
// [R7] Conversion clock is system clock divided by divider field plus one.
// [R8] Start source: software busy write, timer 0, timer 2, timer 1, pin edge.
// [R9] Busy bit is 1 during a conversion and clears when it ends.
// [R10] Busy falling sets the complete flag, which is the interrupt request.
// [R11] Result bytes update at each completion, valid while flag reads 1.
// [R12] Software should poll the complete flag, not the busy bit.
// [R13] Timer 2 source uses low-byte overflow in 8-bit, high-byte in 16-bit.
// [R14] Delayed tracking adds three conversion clocks of tracking after the trigger.
// [R15] Without delayed tracking conversion begins at once on the trigger.
// [R16] Internal sources: track whenever no conversion is in progress.
// [R17] Pin source: track if delayed mode, or pin held low.
// [R18] Configuration bit 0 selects gain 0.5 when clear, 1 when set.
// [R19] Converter runs only while enabled; otherwise shut down, no conversions.
// [R20] 10-bit conversion ends at clock 14, or 17 with delayed tracking.
`timescale 1ns/1ps
module sac_ctrl
    import sac_pkg::*;
#(
    parameter int CODE_W = SAC_CODE_W,
    parameter int DIV_W = SAC_DIV_W
)(
    input wire logic mclk,
    input wire logic nrst,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    output logic [7:0] sfr_rdata,
    input wire logic t0_ovf,
    input wire logic t1_ovf,
    input wire logic t2_low_ovf,
    input wire logic t2_high_ovf,
    input wire logic t2_split8,
    input wire logic external_start_pin,
    input wire logic cmp_in,
    output logic [9:0] dac_code,
    output logic track_en,
    output logic gain_unity,
    output logic converter_powered,
    output logic conversion_busy,
    output logic conversion_complete_flag
);

    if (CODE_W != 10 || DIV_W != 5) begin : g_chk
        $error("sac_ctrl: only a 10-bit code and 5-bit divider are served");
    end

    // Result formatting into high and low bytes
    function automatic logic [15:0] sac_format(
        input logic [9:0] code,
        input logic left,
        input logic eight
    );
        logic [15:0] r;
        if (eight) begin
            r = {code[9:2], 8'h00}; // R4
        end else if (left) begin
            r = {code, 6'h00}; // R2
        end else begin
            r = {6'h00, code}; // R1
        end
        return r; // R3
    endfunction : sac_format

    logic [7:0] cfg_q;
    logic [7:0] res_high_q;
    logic [7:0] res_low_q;
    logic enable_q;
    logic track_mode_q;
    logic done_q;
    logic busy_q;
    logic [2:0] src_q;
    sac_state_e state_q;
    logic [4:0] tick_cnt_q;
    logic eight_q;
    logic [9:0] dac_q;
    logic [9:0] trial_q;
    logic pin_level;
    logic pin_prev_q;
    logic tick;
    logic [7:0] rdata_q;
    logic track_q;

    logic wr_cfg;
    logic wr_ctl;
    logic run_next;
    logic trigger;
    logic finish;
    logic [4:0] end_ticks;
    logic [9:0] dec_code;
    logic [9:0] next_trial;
    logic [15:0] formatted;

    assign wr_cfg = sfr_wr && (sfr_addr == SAC_ADDR_CONFIG);
    assign wr_ctl = sfr_wr && (sfr_addr == SAC_ADDR_CONTROL);
    // Enable as it stands after this edge, so an abort stops the start, sequencer, tracking and busy bit at once
    assign run_next = wr_ctl ? sfr_wdata[SAC_CTL_ENABLE] : enable_q;

    sac_pin_sync u_pin_sync (
        .mclk(mclk),
        .nrst(nrst),
        .pin(external_start_pin),
        .level_q(pin_level)
    );

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            pin_prev_q <= 1'b0;
        end else begin
            pin_prev_q <= pin_level;
        end
    end

    // Start source selection
    always_comb begin
        trigger = 1'b0;
        if (src_q[2]) begin
            trigger = pin_level && !pin_prev_q; // R8
        end else begin
            case (src_q)
                SAC_SRC_SOFT: trigger = wr_ctl && sfr_wdata[SAC_CTL_BUSY]; // R8
                SAC_SRC_T0: trigger = t0_ovf; // R8
                SAC_SRC_T2: trigger = t2_split8 ? t2_low_ovf : t2_high_ovf; // R13
                SAC_SRC_T1: trigger = t1_ovf; // R8
                default: trigger = 1'b0;
            endcase
        end
        trigger = trigger && enable_q && run_next && (state_q == SAC_IDLE); // R19
    end

    sac_clk_div #(
        .DIV_W(DIV_W)
    ) u_clk_div (
        .mclk(mclk),
        .nrst(nrst),
        .run(enable_q),
        .restart(trigger),
        .div(cfg_q[SAC_CFG_DIV_MSB:SAC_CFG_DIV_LSB]),
        .tick_q(tick)
    );

    assign end_ticks = eight_q ? SAC_END_TICKS_8 : SAC_END_TICKS_10; // R5 R6 R20
    assign finish = (state_q == SAC_CONV) && tick && (tick_cnt_q + 5'h01 == end_ticks);

    // Bit decision and next trial
    always_comb begin
        dec_code = cmp_in ? dac_q : (dac_q & ~trial_q);
        if (eight_q && trial_q == SAC_TRIAL_LAST_8) begin
            next_trial = 10'h000; // R4
        end else begin
            next_trial = trial_q >> 1;
        end
    end

    // Sequencer
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            state_q <= SAC_IDLE;
            tick_cnt_q <= 5'h00;
            eight_q <= 1'b0;
        end else if (!run_next) begin
            state_q <= SAC_IDLE; // R19
            tick_cnt_q <= 5'h00;
        end else begin
            case (state_q)
                SAC_IDLE: begin
                    if (trigger) begin
                        eight_q <= cfg_q[SAC_CFG_EIGHT];
                        tick_cnt_q <= 5'h00;
                        state_q <= track_mode_q ? SAC_DELAY : SAC_CONV; // R14 R15
                    end
                end
                SAC_DELAY: begin
                    if (tick) begin
                        if (tick_cnt_q + 5'h01 == SAC_DELAY_TICKS) begin
                            tick_cnt_q <= 5'h00;
                            state_q <= SAC_CONV; // R14
                        end else begin
                            tick_cnt_q <= tick_cnt_q + 5'h01;
                        end
                    end
                end
                SAC_CONV: begin
                    if (finish) begin
                        tick_cnt_q <= 5'h00;
                        state_q <= SAC_IDLE;
                    end else if (tick) begin
                        tick_cnt_q <= tick_cnt_q + 5'h01;
                    end
                end
                default: begin
                    state_q <= SAC_IDLE;
                    tick_cnt_q <= 5'h00;
                end
            endcase
        end
    end

    // Successive approximation register
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            dac_q <= 10'h000;
            trial_q <= 10'h000;
        end else if (state_q != SAC_CONV || !enable_q) begin
            dac_q <= SAC_TRIAL_FIRST;
            trial_q <= SAC_TRIAL_FIRST;
        end else if (tick && trial_q != 10'h000) begin
            dac_q <= dec_code | next_trial;
            trial_q <= next_trial;
        end
    end

    // Track control
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            track_q <= 1'b0;
        end else if (!run_next) begin
            track_q <= 1'b0; // R19
        end else if (trigger) begin
            track_q <= track_mode_q; // R14 R15
        end else if (state_q == SAC_CONV && !finish) begin
            track_q <= 1'b0;
        end else if (state_q == SAC_DELAY) begin
            track_q <= 1'b1; // R14
        end else if (src_q[2]) begin
            track_q <= track_mode_q || !pin_level; // R17
        end else begin
            track_q <= 1'b1; // R16
        end
    end

    // Configuration register
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            cfg_q <= SAC_CFG_RESET;
        end else if (wr_cfg) begin
            cfg_q <= sfr_wdata; // R18
        end
    end

    // Control register fields
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            enable_q <= SAC_CTL_RESET[SAC_CTL_ENABLE];
            track_mode_q <= SAC_CTL_RESET[SAC_CTL_TRACK];
            src_q <= SAC_CTL_RESET[SAC_CTL_SRC_MSB:SAC_CTL_SRC_LSB];
        end else if (wr_ctl) begin
            enable_q <= sfr_wdata[SAC_CTL_ENABLE];
            track_mode_q <= sfr_wdata[SAC_CTL_TRACK];
            src_q <= sfr_wdata[SAC_CTL_SRC_MSB:SAC_CTL_SRC_LSB];
        end
    end

    // Busy bit
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            busy_q <= 1'b0;
        end else if (trigger) begin
            busy_q <= 1'b1; // R9
        end else if (finish || !run_next) begin
            busy_q <= 1'b0; // R9 R19
        end
    end

    // Complete flag; completion wins over a clearing write
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            done_q <= 1'b0;
        end else if (finish) begin
            done_q <= 1'b1; // R10
        end else if (wr_ctl) begin
            done_q <= sfr_wdata[SAC_CTL_DONE];
        end
    end

    assign formatted = sac_format(dec_code, cfg_q[SAC_CFG_JUSTIFY], eight_q);

    // Result bytes
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            res_high_q <= SAC_DATA_RESET;
            res_low_q <= SAC_DATA_RESET;
        end else if (finish) begin
            res_high_q <= formatted[15:8]; // R11
            res_low_q <= formatted[7:0]; // R11
        end else if (sfr_wr && sfr_addr == SAC_ADDR_RES_HIGH) begin
            res_high_q <= sfr_wdata;
        end else if (sfr_wr && sfr_addr == SAC_ADDR_RES_LOW) begin
            res_low_q <= sfr_wdata;
        end
    end

    // Read port, registered
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rdata_q <= 8'h00;
        end else if (sfr_rd) begin
            case (sfr_addr)
                SAC_ADDR_CONFIG: rdata_q <= cfg_q;
                SAC_ADDR_RES_HIGH: rdata_q <= res_high_q;
                SAC_ADDR_RES_LOW: rdata_q <= res_low_q;
                SAC_ADDR_CONTROL: rdata_q <= {enable_q, track_mode_q, done_q, busy_q, 1'b0, src_q}; // R12
                default: rdata_q <= 8'h00;
            endcase
        end
    end

    assign sfr_rdata = rdata_q;
    assign dac_code = dac_q;
    assign track_en = track_q;
    assign gain_unity = cfg_q[SAC_CFG_GAIN]; // R18
    assign converter_powered = enable_q; // R19
    assign conversion_busy = busy_q;
    assign conversion_complete_flag = done_q; // R10

endmodule : sac_ctrl

/* File: test/sac_ctrl_properties.sv */
/*
 * Port checker for sac_ctrl: start, busy length, flag, tracking, power.
 * Assumes configuration changes only through register writes.
 */
`timescale 1ns/1ps
module sac_ctrl_properties
    import sac_pkg::*;
#(
    parameter int CODE_W = SAC_CODE_W,
    parameter int DIV_W = SAC_DIV_W
)(
    input wire logic mclk,
    input wire logic nrst,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_rdata,
    input wire logic t0_ovf,
    input wire logic t1_ovf,
    input wire logic t2_low_ovf,
    input wire logic t2_high_ovf,
    input wire logic t2_split8,
    input wire logic external_start_pin,
    input wire logic cmp_in,
    input wire logic [9:0] dac_code,
    input wire logic track_en,
    input wire logic gain_unity,
    input wire logic converter_powered,
    input wire logic conversion_busy,
    input wire logic conversion_complete_flag
);
    logic [7:0] cfg_q;
    logic [7:0] ctl_q;
    logic [15:0] len_q;
    logic [15:0] ticks;
    logic [15:0] exp_len;
    logic ctl_wr;
    logic trig;
    assign ctl_wr = sfr_wr && sfr_addr == SAC_ADDR_CONTROL;
    assign trig = (ctl_q[2:0] == SAC_SRC_T0 && t0_ovf) || (ctl_q[2:0] == SAC_SRC_T1 && t1_ovf)
        || (ctl_q[2:0] == SAC_SRC_T2 && (t2_split8 ? t2_low_ovf : t2_high_ovf));
    assign ticks = (cfg_q[1] ? 16'h000C : 16'h000E) + (ctl_q[6] ? 16'h0003 : 16'h0000);
    assign exp_len = ticks * ({11'h000, cfg_q[7:3]} + 16'h0001) + 16'h0001;
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            cfg_q <= SAC_CFG_RESET;
        end else if (sfr_wr && sfr_addr == SAC_ADDR_CONFIG) begin
            cfg_q <= sfr_wdata;
        end
    end
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            ctl_q <= SAC_CTL_RESET;
        end else if (ctl_wr) begin
            ctl_q <= sfr_wdata;
        end
    end
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            len_q <= 16'h0000;
        end else begin
            len_q <= conversion_busy ? len_q + 16'h0001 : 16'h0000;
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);
    sequence s_soft;
        ctl_wr && sfr_wdata[7] && sfr_wdata[4] && ctl_q[2:0] == SAC_SRC_SOFT;
    endsequence
    sequence s_done;
        $fell(conversion_busy) && converter_powered;
    endsequence
    AST_SOFT: assert property (s_soft ##0 (converter_powered && !conversion_busy) |=> conversion_busy)
        else $error("software start ignored");
    AST_TIMER: assert property (trig && converter_powered && !conversion_busy |=> conversion_busy)
        else $error("timer start ignored");
    AST_FLAG: assert property (s_done |-> conversion_complete_flag)
        else $error("complete flag not set at busy fall");
    AST_LEN: assert property (s_done |-> len_q == exp_len)
        else $error("conversion length wrong");
    AST_TRACK: assert property ($rose(conversion_busy) |-> track_en == ctl_q[6])
        else $error("tracking wrong at start");
    AST_DAC: assert property ($rose(conversion_busy) && !ctl_q[6] |-> dac_code == 10'h200)
        else $error("first trial code wrong");
    AST_OFF: assert property (!converter_powered |-> !conversion_busy && !track_en)
        else $error("activity while disabled");
    AST_GAIN: assert property (sfr_wr && sfr_addr == SAC_ADDR_CONFIG |-> ##2 gain_unity == $past(sfr_wdata[0], 2))
        else $error("gain select not applied");
    AST_POWER: assert property (ctl_wr |-> ##2 converter_powered == $past(sfr_wdata[7], 2))
        else $error("enable not applied");
endmodule : sac_ctrl_properties

bind sac_ctrl sac_ctrl_properties #(.CODE_W(CODE_W), .DIV_W(DIV_W)) sac_ctrl_properties_inst (
    .mclk(mclk), .nrst(nrst), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .t0_ovf(t0_ovf), .t1_ovf(t1_ovf), .t2_low_ovf(t2_low_ovf),
    .t2_high_ovf(t2_high_ovf), .t2_split8(t2_split8), .external_start_pin(external_start_pin),
    .cmp_in(cmp_in), .dac_code(dac_code), .track_en(track_en), .gain_unity(gain_unity),
    .converter_powered(converter_powered), .conversion_busy(conversion_busy),
    .conversion_complete_flag(conversion_complete_flag)
);

/* File: test/sac_far_model.sv */
/*
 * Far side: analog input level and comparator.
 * Assumes dac_code settles before mclk samples cmp_in.
 */
`timescale 1ns/1ps
module sac_far_model
    import sac_pkg::*;
(
    input wire logic [9:0] dac_code,
    input wire logic [9:0] vin,
    output logic cmp_in
);
    // Input at or above trial code
    assign cmp_in = (vin >= dac_code);
endmodule : sac_far_model

/* File: test/tb_top.sv */
/*
 * Testbench for sac_ctrl: reset values, conversions from every source, abort.
 * Assumes one clock and the comparator model on cmp_in.
 */
`timescale 1ns/1ps
module tb_top
    import sac_pkg::*;
;
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    logic [7:0] sfr_addr = 8'h00;
    logic [7:0] sfr_wdata = 8'h00;
    logic sfr_wr = 1'b0;
    logic sfr_rd = 1'b0;
    logic t0_ovf = 1'b0;
    logic t1_ovf = 1'b0;
    logic t2_low_ovf = 1'b0;
    logic t2_high_ovf = 1'b0;
    logic t2_split8 = 1'b0;
    logic external_start_pin = 1'b0;
    logic [9:0] vin = 10'h000;
    logic [7:0] sfr_rdata;
    logic [9:0] dac_code;
    logic cmp_in, track_en, gain_unity, converter_powered, conversion_busy, conversion_complete_flag;
    logic [7:0] exp_q[$];
    logic rd_seen = 1'b0;
    logic [31:0] seed = 32'h9744;
    logic [2:0] src;
    logic [7:0] cfg;
    logic [7:0] ctl;
    logic [15:0] r;
    int failures = 0;
    int cmp_count = 0;
    int cyc = 0;
    sac_ctrl sac_ctrl_inst (
        .mclk(mclk), .nrst(nrst), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr),
        .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .t0_ovf(t0_ovf), .t1_ovf(t1_ovf), .t2_low_ovf(t2_low_ovf),
        .t2_high_ovf(t2_high_ovf), .t2_split8(t2_split8), .external_start_pin(external_start_pin),
        .cmp_in(cmp_in), .dac_code(dac_code), .track_en(track_en), .gain_unity(gain_unity),
        .converter_powered(converter_powered), .conversion_busy(conversion_busy),
        .conversion_complete_flag(conversion_complete_flag)
    );
    sac_far_model sac_far_model_inst (.dac_code(dac_code), .vin(vin), .cmp_in(cmp_in));
    always #25 mclk = ~mclk;
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    function automatic logic [15:0] fmt(input logic [9:0] c, input logic [7:0] f);
        if (f[1]) return {c[9:2], 8'h00};
        if (f[2]) return {c, 6'h00};
        return {6'h00, c};
    endfunction : fmt
    task automatic summarize();
        $display("compares %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : summarize
    task automatic cmp(input logic [7:0] got, input logic [7:0] e);
        cmp_count++;
        if (got !== e) begin
            failures++;
            $display("[ERR] %0t read %h expected %h", $time, got, e);
        end
    endtask : cmp
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(negedge mclk);
        sfr_wr = 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge mclk);
        sfr_addr = a;
        sfr_rd = 1'b1;
        exp_q.push_back(e);
        @(negedge mclk);
        sfr_rd = 1'b0;
    endtask : rd
    task automatic fire(input logic [2:0] s, input logic low);
        @(negedge mclk);
        case (s)
            SAC_SRC_T0: t0_ovf = 1'b1;
            SAC_SRC_T1: t1_ovf = 1'b1;
            SAC_SRC_T2: {t2_low_ovf, t2_high_ovf} = {low, ~low};
            default: external_start_pin = 1'b1;
        endcase
        @(negedge mclk);
        {t0_ovf, t1_ovf, t2_low_ovf, t2_high_ovf} = 4'h0;
    endtask : fire
    task automatic wait_flag();
        int n;
        n = 0;
        while (conversion_complete_flag !== 1'b1 && n < 2000) begin
            @(negedge mclk);
            n++;
        end
        if (n == 2000) begin
            failures++;
            $display("[ERR] %0t no completion", $time);
        end
    endtask : wait_flag
    always @(posedge mclk) rd_seen <= sfr_rd;
    always @(negedge mclk) begin
        if (rd_seen === 1'b1) cmp(sfr_rdata, exp_q.pop_front());
    end
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            failures++;
            $display("[ERR] %0t timeout", $time);
            summarize();
        end
    end
    initial begin
        repeat (20) @(negedge mclk);
        nrst = 1'b1;
        rd(SAC_ADDR_CONFIG, SAC_CFG_RESET);
        rd(SAC_ADDR_CONTROL, SAC_CTL_RESET);
        rd(SAC_ADDR_RES_HIGH, SAC_DATA_RESET);
        rd(SAC_ADDR_RES_LOW, SAC_DATA_RESET);
        wr(8'h00, 8'hFF);
        rd(8'h00, 8'h00);
        $display("test reset done");
        for (int i = 0; i < 10; i++) begin
            seed = lfsr(seed);
            src = (i < 5) ? i[2:0] : seed[2:0];
            cfg = (i == 0) ? 8'h00 : (i == 1) ? 8'h04 : seed[15:8];
            vin = (i < 2) ? 10'h3FF : seed[29:20];
            t2_split8 = seed[17];
            ctl = {1'b1, seed[16], 3'b000, src};
            wr(SAC_ADDR_CONFIG, cfg);
            wr(SAC_ADDR_CONTROL, ctl);
            rd(SAC_ADDR_CONFIG, cfg);
            if (src == SAC_SRC_T2) begin
                fire(src, ~t2_split8);
                rd(SAC_ADDR_CONTROL, ctl);
            end
            if (src == SAC_SRC_SOFT) wr(SAC_ADDR_CONTROL, ctl | 8'h10);
            else fire(src, t2_split8);
            wait_flag();
            rd(SAC_ADDR_CONTROL, ctl | 8'h20);
            r = fmt(vin, cfg);
            rd(SAC_ADDR_RES_HIGH, r[15:8]);
            rd(SAC_ADDR_RES_LOW, r[7:0]);
            external_start_pin = 1'b0;
            wr(SAC_ADDR_CONTROL, ctl);
            $display("test conversion %0d done", i);
        end
        wr(SAC_ADDR_CONFIG, 8'hF8);
        wr(SAC_ADDR_CONTROL, 8'h80);
        wr(SAC_ADDR_CONTROL, 8'h90);
        repeat (20) @(negedge mclk);
        wr(SAC_ADDR_CONTROL, 8'h00);
        rd(SAC_ADDR_CONTROL, 8'h00);
        wr(SAC_ADDR_CONTROL, 8'h10);
        rd(SAC_ADDR_CONTROL, 8'h00);
        rd(SAC_ADDR_RES_HIGH, r[15:8]);
        $display("test abort done");
        repeat (4) @(negedge mclk);
        if (exp_q.size() != 0) failures++;
        summarize();
    end
endmodule : tb_top
